// ==== ped_defs.svh ====
/*
  Offsets, field positions, page codes and reset values of the paged
  edge-detect I/O block.
  Assumes a 16-byte I/O window and an 8-bit host data path.
*/
`ifndef PED_DEFS_SVH
`define PED_DEFS_SVH

// register offsets within the window
`define PED_OFF_PORT_LAST 4'h5
`define PED_OFF_IRQ 4'h6
`define PED_OFF_PAGE 4'h7
`define PED_OFF_PG_FIRST 4'h8
`define PED_OFF_PG_LAST 4'hA

// fields of the page select and write lock register
`define PED_PAGE_MSB 7
`define PED_PAGE_LSB 6
`define PED_LOCK_MSB 5

// page numbers
`define PED_PG_NONE 2'h0
`define PED_PG_POL 2'h1
`define PED_PG_EN 2'h2
`define PED_PG_STAT 2'h3

// reset and idle values
`define PED_RST_BYTE 8'h00
`define PED_PIN_LOW 48'h000000000000

`endif

// ==== ped_pkg.sv ====
/*
  Types of the paged edge-detect I/O block: host request carrier and
  the full state record of the top module.
  Assumes nothing beyond ped_defs.svh for the numbers.
*/
package ped_pkg;

  // one host access, sampled on clk_i
  typedef struct packed {
    logic rd;
    logic wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } ped_bus_req_t;

  // whole state of the block
  typedef struct packed {
    logic [5:0][7:0] dout;
    logic [5:0] lock;
    logic [1:0] page;
    logic [2:0][7:0] pol;
    logic [2:0][7:0] enab;
    logic [2:0][7:0] stat;
    logic [47:0] s1;
    logic [47:0] s2;
    logic [47:0] prev;
    logic [5:0] j1;
    logic [5:0] j2;
    logic [7:0] rdata;
    logic rvalid;
    logic irq;
  } ped_state_t;

endpackage

// ==== ped_dio48.sv ====
/*
  Top of the paged edge-detect 48-line digital I/O block: host register
  decode, six open-drain ports, write locks and edge capture on ports 0-2.
  Assumes host strobes synchronous to clk_i, pins and base jumpers
  asynchronous, and external pull-ups on every line.
*/
`timescale 1ns/10ps
`include "ped_defs.svh"

module ped_dio48 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire ped_pkg::ped_bus_req_t bus_i,
  input wire logic [5:0] base_address_jumpers_i,
  input wire logic [47:0] pin_i,
  output logic [47:0] pin_o,
  output logic [47:0] pin_oe_o,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic hit_o,
  output logic irq_o
);

  ped_pkg::ped_state_t r;
  ped_pkg::ped_state_t n;

  logic hit;
  logic wr;
  logic rd;
  logic [3:0] off;
  logic [1:0] pidx;
  logic [7:0] rmux;
  logic [2:0] port_irq_pending;
  logic [5:0][7:0] lvl;
  logic [23:0] edge_set;
  logic [23:0] pol_f;
  logic [23:0] en_f;
  logic [2:0] clr;
  logic [2:0][7:0] stat_nx;

  // window claim, used for both directions
  function automatic logic ped_hit(input logic [9:0] a, input logic [5:0] j);
    ped_hit = (a[9:4] == j);
  endfunction

  // true for the three paged offsets
  function automatic logic ped_paged(input logic [3:0] o);
    ped_paged = (o >= `PED_OFF_PG_FIRST) && (o <= `PED_OFF_PG_LAST);
  endfunction

  // decode of the host access
  assign off = bus_i.addr[3:0];
  assign pidx = off[1:0]; // offsets 8..10 land on 0..2
  assign hit = ped_hit(bus_i.addr, r.j2);
  assign wr = bus_i.wr & hit;
  assign rd = bus_i.rd & hit;
  assign hit_o = hit & (bus_i.rd | bus_i.wr);

  // flat views of the paged registers and pin samples
  assign lvl = r.s2;
  assign pol_f = r.pol;
  assign en_f = r.enab;

  // edge capture exists for the low 24 lines only
  genvar g;
  generate
    for (g = 0; g < 24; g = g + 1) begin : g_edge
      logic rise;
      logic fall;
      assign rise = r.s2[g] & ~r.prev[g];
      assign fall = ~r.s2[g] & r.prev[g];
      assign edge_set[g] = en_f[g] & (pol_f[g] ? rise : fall);
    end
    for (g = 0; g < 3; g = g + 1) begin : g_port
      // a write in page 3 wipes the whole port
      assign clr[g] = wr && (r.page == `PED_PG_STAT) &&
                      (off == (`PED_OFF_PG_FIRST + 4'(g)));
      // set wins over clear so an edge in the wipe cycle survives
      assign stat_nx[g] = (clr[g] ? `PED_RST_BYTE : r.stat[g]) |
                          edge_set[g*8 +: 8];
      assign port_irq_pending[g] = |r.stat[g];
    end
  endgenerate

  // read data selection
  always_comb begin
    rmux = `PED_RST_BYTE;
    if (off <= `PED_OFF_PORT_LAST) begin
      rmux = ~lvl[off[2:0]];
    end else if (off == `PED_OFF_IRQ) begin
      rmux = {5'h00, port_irq_pending};
    end else if (ped_paged(off)) begin
      case (r.page)
        `PED_PG_POL: rmux = r.pol[pidx];
        `PED_PG_EN: rmux = r.enab[pidx];
        `PED_PG_STAT: rmux = r.stat[pidx];
        default: rmux = `PED_RST_BYTE;
      endcase
    end else begin
      rmux = `PED_RST_BYTE;
    end
  end

  // next state; offset 7 read and 11-15 fall through as zero
  always_comb begin
    n = r;
    n.s1 = pin_i;
    n.s2 = r.s1;
    n.prev = r.s2;
    n.j1 = base_address_jumpers_i;
    n.j2 = r.j1;
    n.stat = stat_nx;
    n.irq = |port_irq_pending;
    n.rvalid = rd;
    if (rd) begin
      n.rdata = rmux;
    end
    if (wr) begin
      if (off <= `PED_OFF_PORT_LAST) begin
        if (!r.lock[off[2:0]]) begin
          n.dout[off[2:0]] = bus_i.wdata;
        end
      end else if (off == `PED_OFF_PAGE) begin
        n.page = bus_i.wdata[`PED_PAGE_MSB:`PED_PAGE_LSB];
        n.lock = bus_i.wdata[`PED_LOCK_MSB:0];
      end else if (ped_paged(off)) begin
        case (r.page)
          `PED_PG_POL: n.pol[pidx] = bus_i.wdata;
          `PED_PG_EN: n.enab[pidx] = bus_i.wdata;
          default: n.page = r.page; // page 3 clear lives in stat_nx
        endcase
      end
    end
  end

  // async clear so the port releases all pins at power up
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= n;
    end
  end

  // outputs; pins are never driven high, only pulled low
  assign pin_o = `PED_PIN_LOW;
  assign pin_oe_o = r.dout;
  assign rdata_o = r.rdata;
  assign rvalid_o = r.rvalid;
  assign irq_o = r.irq;

  // helpers read only by the checks below
  logic [7:0] lvl3_h;
  logic [7:0] stat0_h;
  logic [1:0] wpage_h;
  logic [7:0] wdata_h;
  assign lvl3_h = r.s2[31:24];
  assign stat0_h = r.stat[0];
  assign wpage_h = bus_i.wdata[7:6];
  assign wdata_h = bus_i.wdata;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // a locked port keeps its value
  lock_blocks_a: assert property (
    ce_i && wr && off == 4'h0 && r.lock[0] |=> $stable(r.dout[0]))
    else $error("write to locked port changed it");

  // an unlocked write lands and reaches the pin enables
  port_write_a: assert property (
    ce_i && wr && off == 4'h1 && !r.lock[1] |=> r.dout[1] == $past(wdata_h))
    else $error("port write lost");

  open_drain_a: assert property (
    ce_i && wr && off == 4'h2 && !r.lock[2]
    |=> pin_oe_o[23:16] == $past(wdata_h) && pin_o[23:16] == 8'h00)
    else $error("pin drive does not follow port data");

  read_inv_a: assert property (
    ce_i && rd && off == 4'h3 |=> rvalid_o && rdata_o == ~$past(lvl3_h))
    else $error("port read not inverted pin level");

  page_sel_a: assert property (
    ce_i && wr && off == `PED_OFF_PAGE |=> r.page == $past(wpage_h))
    else $error("page number not taken");

  edge_needs_two_a: assert property (
    edge_set[0] |-> r.s2[0] != r.prev[0])
    else $error("edge without two differing samples");

  edge_polar_a: assert property (
    edge_set[5] |-> r.s2[5] == r.pol[0][5])
    else $error("edge of wrong polarity captured");

  edge_sticky_a: assert property (
    ce_i && edge_set[0] |=> r.stat[0][0])
    else $error("edge not recorded");

  stat_hold_a: assert property (
    ce_i && r.stat[0][0] && !clr[0] |=> r.stat[0][0])
    else $error("status bit dropped without clear");

  disabled_quiet_a: assert property (
    ce_i && !r.enab[2][0] && !r.stat[2][0] |=> !r.stat[2][0])
    else $error("disabled line recorded an edge");

  clear_wipes_a: assert property (
    ce_i && clr[1] && edge_set[15:8] == 8'h00 |=> r.stat[1] == 8'h00)
    else $error("status not wiped by write");

  stat_read_a: assert property (
    ce_i && rd && off == 4'h8 && r.page == `PED_PG_STAT
    |=> rdata_o == $past(stat0_h))
    else $error("status read wrong");

  pend_read_a: assert property (
    ce_i && rd && off == `PED_OFF_IRQ
    |=> rdata_o == {5'h00, $past(port_irq_pending)})
    else $error("pending summary read wrong");

  irq_follow_a: assert property (
    ce_i && (|r.stat) |=> irq_o)
    else $error("irq missing while edge pending");

  reserved_zero_a: assert property (
    ce_i && rd && off == 4'hC |=> rvalid_o && rdata_o == 8'h00)
    else $error("reserved offset not claimed as zero");

  foreign_addr_a: assert property (
    ce_i && bus_i.rd && !hit |=> !rvalid_o)
    else $error("answered outside window");

  // clock enable low must freeze every bit of state
  ce_freeze_a: assert property (
    !ce_i |=> r == $past(r))
    else $error("state moved while clock enable low");

  // lock bits come from the low six data bits of offset 7
  lock_take_a: assert property (
    ce_i && wr && off == `PED_OFF_PAGE |=> r.lock == $past(wdata_h[5:0]))
    else $error("lock bits not taken");

  // polarity register write in page 1
  pol_write_a: assert property (
    ce_i && wr && off == 4'hA && r.page == `PED_PG_POL
    |=> r.pol[2] == $past(wdata_h))
    else $error("polarity write lost");

  // enable register write in page 2
  en_write_a: assert property (
    ce_i && wr && off == 4'h9 && r.page == `PED_PG_EN
    |=> r.enab[1] == $past(wdata_h))
    else $error("enable write lost");

  // page 0 maps nothing, so paged writes leave all settings alone
  page0_quiet_a: assert property (
    ce_i && wr && ped_paged(off) && r.page == `PED_PG_NONE
    |=> $stable(r.pol) && $stable(r.enab))
    else $error("page 0 write changed a setting");

  // offset 7 has no read function and answers zero
  page_read_a: assert property (
    ce_i && rd && off == `PED_OFF_PAGE |=> rvalid_o && rdata_o == 8'h00)
    else $error("offset 7 read not zero");

  // polarity read back in page 1
  pol_read_a: assert property (
    ce_i && rd && off == 4'h9 && r.page == `PED_PG_POL
    |=> rdata_o == $past(r.pol[1]))
    else $error("polarity read wrong");

  // enable read back in page 2
  en_read_a: assert property (
    ce_i && rd && off == 4'h8 && r.page == `PED_PG_EN
    |=> rdata_o == $past(r.enab[0]))
    else $error("enable read wrong");

  // status of the last port read in page 3
  stat_read2_a: assert property (
    ce_i && rd && off == 4'hA && r.page == `PED_PG_STAT
    |=> rdata_o == $past(r.stat[2]))
    else $error("port 2 status read wrong");

  // an edge on the top line of port 2 is recorded
  edge_top_a: assert property (
    ce_i && edge_set[23] |=> r.stat[2][7])
    else $error("port 2 edge not recorded");

  // a status bit never rises without an edge behind it
  no_ghost_a: assert property (
    ce_i && !r.stat[0][1] && !edge_set[1] |=> !r.stat[0][1])
    else $error("status set without edge");

  // irq drops once every status bit is clear
  irq_quiet_a: assert property (
    ce_i && r.stat == '0 |=> !irq_o)
    else $error("irq without pending edge");

  // read valid is a single pulse per accepted read
  rvalid_pulse_a: assert property (
    ce_i && !rd |=> !rvalid_o)
    else $error("read valid without read");

  // writes outside the window leave the ports alone
  foreign_write_a: assert property (
    ce_i && bus_i.wr && !hit |=> $stable(r.dout))
    else $error("write outside window landed");

  // main scenarios
  page_write_c: cover property (ce_i && wr && off == `PED_OFF_PAGE && wpage_h == 2'h3);
  lock_write_c: cover property (ce_i && wr && off == 4'h4 && r.lock[4]);
  edge_seen_c: cover property (ce_i && edge_set[16] ##1 irq_o);
  clear_race_c: cover property (ce_i && clr[0] && |edge_set[7:0]);
  stat_read_c: cover property (ce_i && rd && r.page == `PED_PG_STAT && off == 4'hA);

endmodule // ped_dio48

// ==== ped_pin_model.sv ====
/*
  Line model for the far side of the 48 lines: pull-ups plus an external
  driver that can pull any line low.
  Assumes pin_oe_i high means the block pulls the line low.
*/
`timescale 1ns/10ps

module ped_pin_model (
  input wire logic [47:0] pin_oe_i,
  input wire logic [47:0] ext_low_i,
  output logic [47:0] level_o
);
  // wired-and of both drivers; a released line floats up to 1
  assign level_o = ~(pin_oe_i | ext_low_i);
endmodule // ped_pin_model

// ==== tb_top.sv ====
/*
  Self-checking bench of the paged edge-detect I/O block: host register
  accesses through strobe tasks, lines driven through the pin model.
  Assumes base jumpers fixed at 0x200 and ce_i held high except for one write issued with it low.
*/
`timescale 1ns/10ps

module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  ped_pkg::ped_bus_req_t bus = '0;
  logic [47:0] ext = 48'h000000000000;
  logic [47:0] lvl, pin_o, pin_oe_o, e;
  logic [7:0] rdata_o;
  logic rvalid_o, hit_o, irq_o;
  int mismatches = 0;
  int total_checks = 0;

  always #2 clk_i = ~clk_i;

  ped_dio48 uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .bus_i(bus),
    .base_address_jumpers_i(6'h20), .pin_i(lvl), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .hit_o(hit_o), .irq_o(irq_o));
  ped_pin_model lines (.pin_oe_i(pin_oe_o), .ext_low_i(ext), .level_o(lvl));

  task automatic chk(input logic [47:0] g, input logic [47:0] x);
    total_checks++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] off, input logic [7:0] d);
    @(negedge clk_i);
    bus = '{rd: 1'b0, wr: 1'b1, addr: {6'h20, off}, wdata: d};
    @(negedge clk_i);
    bus.wr = 1'b0;
  endtask

  // read at a full address; v says whether the window claims it
  task automatic rda(input logic [9:0] a, input logic v, input logic [7:0] x);
    @(negedge clk_i);
    bus = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    #1 chk(hit_o, v);
    @(negedge clk_i);
    bus.rd = 1'b0;
    chk(rvalid_o, v);
    if (v) chk(rdata_o, x);
  endtask

  task automatic rd(input logic [3:0] off, input logic [7:0] x);
    rda({6'h20, off}, 1'b1, x);
  endtask

  task automatic settle();
    repeat (5) @(negedge clk_i);
  endtask

  // cut a hung run short
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end

  initial begin
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    settle();
    rd(4'h0, 8'h00);
    rd(4'h6, 8'h00);
    for (int p = 1; p < 3; p++) begin
      wr(4'h7, {p[1:0], 6'h00});
      rd(4'h8, 8'h00);
    end
    wr(4'h7, 8'h00);
    // every port driven with its own pattern, read back inverted from lines
    for (int i = 0; i < 6; i++) begin
      wr(i[3:0], {i[3:0], 4'hA});
      e[8*i+:8] = {i[3:0], 4'hA};
    end
    chk(pin_oe_o, e);
    for (int i = 0; i < 6; i++) rd(i[3:0], {i[3:0], 4'hA});
    // locks on ports 0, 2 and 4 only
    wr(4'h7, 8'h15);
    for (int i = 0; i < 6; i++) wr(i[3:0], 8'h00);
    e[15:8] = 8'h00;
    e[31:24] = 8'h00;
    e[47:40] = 8'h00;
    chk(pin_oe_o, e);
    rd(4'h8, 8'h00);
    rd(4'h7, 8'h00);
    rd(4'hB, 8'h00);
    rda(10'h300, 1'b0, 8'h00);
    wr(4'h7, 8'h00);
    for (int i = 0; i < 6; i++) wr(i[3:0], 8'h00);
    chk(pin_oe_o, 48'h000000000000);
    ext[31:24] = 8'hA5;
    settle();
    rd(4'h3, 8'hA5);
    ext = 48'h000000000000;
    // polarity and enable pages, then status page
    wr(4'h7, 8'h40);
    wr(4'h8, 8'h0F);
    wr(4'hA, 8'h00);
    rd(4'h8, 8'h0F);
    wr(4'h7, 8'h80);
    wr(4'h8, 8'h33);
    wr(4'hA, 8'hFF);
    rd(4'hA, 8'hFF);
    wr(4'h7, 8'hC0);
    rd(4'h8, 8'h00);
    ext[7:0] = 8'hFF;
    ext[23:16] = 8'hFF;
    settle();
    rd(4'h8, 8'h30);
    rd(4'h9, 8'h00);
    rd(4'hA, 8'hFF);
    rd(4'h6, 8'h05);
    chk(irq_o, 1'b1);
    ext = 48'h000000000000;
    settle();
    rd(4'h8, 8'h33);
    wr(4'h8, 8'h5A);
    rd(4'h8, 8'h00);
    rd(4'h6, 8'h04);
    wr(4'hA, 8'h00);
    rd(4'hA, 8'h00);
    settle();
    chk(irq_o, 1'b0);
    // clock enable low drops a write to an unlocked port
    @(negedge clk_i);
    ce = 1'b0;
    wr(4'h1, 8'h3C);
    ce = 1'b1;
    chk(pin_oe_o[15:8], 8'h00);
    // mid-run reset clears driven lines
    wr(4'h1, 8'hFF);
    rst_i = 1'b1;
    #1 chk(pin_oe_o, 48'h000000000000);
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    settle();
    rd(4'h1, 8'h00);
    finish_test();
  end
endmodule // tb_top
